// [include/clr_pkg.sv]
// Package for the configuration-load, literal-return and rotate executor.
// Assumes a 12-bit instruction word, 8-bit data path and 5-bit file address.
package clr_pkg;
    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [11:0] OP_CFG_LOAD   = 12'h002; // Accumulator to config
    localparam logic [3:0]  OP_RET_HI     = 4'h8;    // Upper nibble of return
    localparam logic [5:0]  OP_ROT_HI     = 6'h0D;   // Upper six bits of rotate
    localparam int          DEST_BIT      = 5;       // Destination select bit
    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int          DATA_W        = 8;
    localparam int          FADDR_W       = 5;
    localparam int          PC_W          = 9;
    localparam logic [7:0]  ACC_RST       = 8'h00;
    localparam logic [7:0]  CFG_RST       = 8'hFF;
    localparam logic        CARRY_RST     = 1'b0;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          RET_CYCLES    = 2;       // Literal return length
    typedef enum logic [1:0] {CLR_IDLE, CLR_RET2} clr_state_t;
endpackage

// [src/clr_file_mem.sv]
// Small file-register memory with registered read data.
// Assumes one write port and one read port on the core clock.
`timescale 1ns/10ps
`default_nettype none
module clr_file_mem #(
    parameter int AW = 5,
    parameter int DW = 8
) (
    input  wire logic          clock_i,   // Core clock
    input  wire logic          we_i,      // Write strobe
    input  wire logic [AW-1:0] waddr_i,   // Write address
    input  wire logic [DW-1:0] wdata_i,   // Write data
    input  wire logic [AW-1:0] raddr_i,   // Read address
    output logic      [DW-1:0] rdata_o    // Registered read data
);
    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [DW-1:0] mem [0:(1<<AW)-1];     // Contents undefined at power-up

    // Array write; a plain clocked process, since the array has no reset and
    // its power-up contents may be loaded from outside the core logic
    always @(posedge clock_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // Registered read; same-cycle write is not forwarded
    always_ff @(posedge clock_i)
    begin
        rdata_o <= mem[raddr_i];
    end
endmodule // clr_file_mem
`default_nettype wire

// [src/clr_exec.sv]
// Executor for config load, literal return and rotate-left through carry.
// Assumes instr_valid_i is held until instr_ready_o; rotate reads the file
// register the cycle before, so a rotate takes one fetch cycle plus one.
// Operation
// - Config opcode copies accumulator to config, flags kept
// - Literal return loads low eight bits into accumulator
// - Literal return reloads PC from stack top
// - Literal return: one word, two cycles, flags kept
// - Rotate left through carry, only carry changes
// - Destination bit selects accumulator or file register
`timescale 1ns/10ps
`default_nettype none
module clr_exec (
    input  wire logic                        clock_i,          // Core clock
    input  wire logic                        srst_i,           // Sync reset
    input  wire logic                        instr_valid_i,    // Instruction present
    input  wire logic [11:0]                 instr_i,          // Instruction word
    input  wire logic [clr_pkg::PC_W-1:0]    stack_top_entry_i,// Return address
    input  wire logic                        zero_i,           // Zero flag in
    output logic                             instr_ready_o,    // Instruction retired
    output logic                             stack_pop_o,      // Pop the stack
    output logic                             pc_load_o,        // PC reload pulse
    output logic      [clr_pkg::PC_W-1:0]    pc_o,             // New PC value
    output logic      [7:0]                  acc_o,            // Accumulator
    output logic      [7:0]                  cfg_o,            // Timer config
    output logic                             carry_o,          // Carry flag
    output logic                             zero_o            // Zero flag out
);
    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    function automatic logic is_ret(input logic [11:0] w);
        return w[11:8] == clr_pkg::OP_RET_HI;
    endfunction
    function automatic logic is_rot(input logic [11:0] w);
        return w[11:6] == clr_pkg::OP_ROT_HI;
    endfunction

    typedef struct packed {
        clr_pkg::clr_state_t     st;     // Sequencer state
        logic                    rd_ok;  // File read data valid for rotate
        logic [7:0]              acc;    // Accumulator
        logic [7:0]              cfg;    // Timer/prescaler config
        logic                    carry;  // Carry flag
        logic                    pcl;    // PC load pulse
        logic [clr_pkg::PC_W-1:0] pc;    // Loaded PC
    } clr_state_s_t;

    clr_state_s_t cur;                   // Registered state
    clr_state_s_t next_cur;              // Next state
    logic         ready;                 // Retire this cycle
    logic         fwe;                   // File write strobe
    logic [7:0]   fwdata;                // File write data
    logic [7:0]   frdata;                // File read data
    logic [7:0]   rot;                   // Rotated value
    logic         cfg_go;                // Config load taken this cycle
    logic         ret_go;                // Literal return taken this cycle
    logic         rot_done;              // Rotate retires this cycle

    // Rotate shared by both destinations
    assign rot = {frdata[6:0], cur.carry};

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_cur     = cur;
        next_cur.pcl = 1'b0;
        ready        = 1'b0;
        fwe          = 1'b0;
        fwdata       = rot;
        unique case (cur.st)
            clr_pkg::CLR_IDLE:
            begin
                if (instr_valid_i && instr_i == clr_pkg::OP_CFG_LOAD)
                begin
                    next_cur.cfg = cur.acc;
                    ready        = 1'b1;
                end
                else if (instr_valid_i && is_ret(instr_i))
                begin
                    // First cycle: literal in, PC from stack top
                    next_cur.acc = instr_i[7:0];
                    next_cur.pc  = stack_top_entry_i;
                    next_cur.pcl = 1'b1;
                    next_cur.st  = clr_pkg::CLR_RET2;
                end
                else if (instr_valid_i && is_rot(instr_i))
                begin
                    // Wait one cycle for the registered read
                    if (cur.rd_ok)
                    begin
                        next_cur.carry = frdata[7];
                        if (instr_i[clr_pkg::DEST_BIT])
                        begin
                            fwe = 1'b1;
                        end
                        else
                        begin
                            next_cur.acc = rot;
                        end
                        ready          = 1'b1;
                        next_cur.rd_ok = 1'b0;
                    end
                    else
                    begin
                        next_cur.rd_ok = 1'b1;
                    end
                end
                else if (instr_valid_i)
                begin
                    ready = 1'b1;  // Other opcodes belong elsewhere
                end
            end
            clr_pkg::CLR_RET2:
            begin
                // Second cycle: pipeline flush slot
                ready       = 1'b1;
                next_cur.st = clr_pkg::CLR_IDLE;
            end
        endcase
    end

    // Register the whole state
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            cur <= '{st: clr_pkg::CLR_IDLE, rd_ok: 1'b0, acc: clr_pkg::ACC_RST,
                     cfg: clr_pkg::CFG_RST, carry: clr_pkg::CARRY_RST,
                     pcl: 1'b0, pc: '0};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------------
    // File registers
    // ------------------------------------------------------------------
    clr_file_mem #(.AW(clr_pkg::FADDR_W), .DW(clr_pkg::DATA_W)) u_mem (
        .clock_i (clock_i),
        .we_i    (fwe),
        .waddr_i (instr_i[4:0]),
        .wdata_i (fwdata),
        .raddr_i (instr_i[4:0]),
        .rdata_o (frdata)
    );

    // Outputs; zero flag is never touched by this block
    assign instr_ready_o = ready;
    assign stack_pop_o   = cur.pcl;
    assign pc_load_o     = cur.pcl;
    assign pc_o          = cur.pc;
    assign acc_o         = cur.acc;
    assign cfg_o         = cur.cfg;
    assign carry_o       = cur.carry;
    assign zero_o        = zero_i;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    // Qualified events shared by the checks below
    assign cfg_go   = instr_valid_i && instr_i == clr_pkg::OP_CFG_LOAD
                      && cur.st == clr_pkg::CLR_IDLE;
    assign ret_go   = instr_valid_i && is_ret(instr_i) && cur.st == clr_pkg::CLR_IDLE;
    assign rot_done = ready && is_rot(instr_i) && cur.st == clr_pkg::CLR_IDLE;

    // Rotate first cycle: the file read is still in flight
    sequence rot_issue;
        instr_valid_i && is_rot(instr_i) && cur.st == clr_pkg::CLR_IDLE && !cur.rd_ok;
    endsequence

    sequence ret_start;
        instr_valid_i && is_ret(instr_i) && cur.st == clr_pkg::CLR_IDLE;
    endsequence

    cfg_copy_a: assert property (instr_valid_i && instr_i == clr_pkg::OP_CFG_LOAD
        && cur.st == clr_pkg::CLR_IDLE |=> cfg_o == $past(acc_o) && carry_o == $past(carry_o))
        else $error("config load wrong");
    ret_lit_a: assert property (ret_start |=> acc_o == $past(instr_i[7:0]))
        else $error("literal not loaded");
    ret_pc_a: assert property (ret_start |=> pc_load_o && pc_o == $past(stack_top_entry_i))
        else $error("pc not reloaded");
    ret_len_a: assert property (ret_start |-> !instr_ready_o ##1 instr_ready_o)
        else $error("return not two cycles");
    ret_flags_a: assert property (ret_start |=> carry_o == $past(carry_o))
        else $error("return changed carry");
    rot_carry_a: assert property (ready && is_rot(instr_i) && cur.st == clr_pkg::CLR_IDLE
        |=> carry_o == $past(frdata[7])) else $error("carry wrong");
    rot_acc_a: assert property (ready && is_rot(instr_i) && !instr_i[clr_pkg::DEST_BIT]
        && cur.st == clr_pkg::CLR_IDLE |=> acc_o == {$past(frdata[6:0]), $past(carry_o)})
        else $error("rotate to acc wrong");
    rot_file_a: assert property (fwe |-> instr_i[clr_pkg::DEST_BIT]
        && fwdata == {frdata[6:0], carry_o}) else $error("rotate to file wrong");

    // ------------------------------------------------------------------
    // Hold, length and pulse checks
    // ------------------------------------------------------------------
    // Each hold pairs with a copy check above: a copy at the wrong moment
    // trips the hold, a copy that never happens trips the copy check
    rot_len_a: assert property (rot_issue |-> !instr_ready_o ##1 instr_ready_o)
        else $error("rotate not read then retired");
    acc_hold_a: assert property (!ret_go && !(rot_done && !instr_i[clr_pkg::DEST_BIT])
        |=> $stable(acc_o)) else $error("accumulator changed unasked");
    cfg_hold_a: assert property (!cfg_go |=> $stable(cfg_o))
        else $error("config changed unasked");
    pc_hold_a: assert property (!ret_go |=> $stable(pc_o))
        else $error("pc changed unasked");
    pop_pulse_a: assert property (stack_pop_o |=> !stack_pop_o)
        else $error("stack pop longer than a cycle");
    carry_hold_a: assert property (!rot_done |=> $stable(carry_o))
        else $error("carry changed outside rotate");
    rot_keep_a: assert property (rot_done && instr_i[clr_pkg::DEST_BIT]
        |=> $stable(acc_o))
        else $error("file rotate touched accumulator");
endmodule // clr_exec
`default_nettype wire

// [verification/tb_clr_exec.sv]
// Self-checking bench for the config-load, literal-return and rotate executor.
// Assumes clr_pkg is compiled first; file registers are preloaded by hierarchy.
`timescale 1ns/10ps
`default_nettype none
module tb_clr_exec;
    // --------------------------------------------------------------
    // Signals and scoreboard
    // --------------------------------------------------------------
    typedef struct {logic [7:0] acc, am, cfg; logic [8:0] pc; logic pl, cy;} clr_exp_t;
    logic                       clock_i = 1'b0;
    logic                       srst_i = 1'b1;
    logic                       instr_valid_i = 1'b0;
    logic                       zero_i = 1'b0;
    logic [11:0]                instr_i = 12'h000;
    logic [clr_pkg::PC_W-1:0]   stack_top_entry_i = 9'h000;
    logic [clr_pkg::PC_W-1:0]   pc_o;
    logic                       instr_ready_o, stack_pop_o, pc_load_o, carry_o, zero_o;
    logic [7:0]                 acc_o, cfg_o, m_acc, m_cfg, k, r;
    logic [7:0]                 fm [32];  // Mirror of the file registers
    logic [4:0]                 fa;
    logic                       m_cy, d_bit;
    logic [11:0]                bad [3] = '{12'h000, 12'hFFF, 12'h001}; // Opcodes not ours
    int                         fails = 0;
    int                         cmp_count = 0;
    int                         seed = 32'hCEFA0D94;
    clr_exp_t                   q [$];  // Oldest expectation first
    clr_exp_t                   e, d;
    // Clock and a zero flag that keeps moving so passthrough is seen
    always #4 clock_i = ~clock_i;
    always @(posedge clock_i)
        #1 zero_i = ~zero_i;
    clr_exec u_clr_exec (.clock_i(clock_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .stack_top_entry_i(stack_top_entry_i), .zero_i(zero_i),
        .instr_ready_o(instr_ready_o), .stack_pop_o(stack_pop_o), .pc_load_o(pc_load_o),
        .pc_o(pc_o), .acc_o(acc_o), .cfg_o(cfg_o), .carry_o(carry_o), .zero_o(zero_o));
    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Presents one word, notes its result, checks the retire latency
    task automatic issue(input logic [11:0] op, input int lat, input clr_exp_t x);
        int n;
        n = 0;
        q.push_back(x);
        instr_valid_i = 1'b1;
        instr_i = op;
        @(negedge clock_i);
        while (instr_ready_o !== 1'b1 && n < 4)
        begin
            @(negedge clock_i);
            n++;
        end
        if (n == 4)
        begin
            fails++;
            conclude();
        end
        chk(9'(n), 9'(lat));
        @(posedge clock_i);
        #1;
    endtask
    // --------------------------------------------------------------
    // Monitor: pulses in the retire cycle, registers just after it
    // --------------------------------------------------------------
    always @(negedge clock_i)
        if (instr_ready_o === 1'b1 && q.size() == 0)
            fails++;  // A retire that nobody asked for
        else if (instr_ready_o === 1'b1)
        begin
            e = q.pop_front();
            chk({7'h00, pc_load_o, stack_pop_o}, {7'h00, e.pl, e.pl});
            if (e.pl)
                chk(pc_o, e.pc);
            chk({8'h00, zero_o}, {8'h00, zero_i});
            @(posedge clock_i);
            #1;
            chk({1'b0, acc_o & e.am}, {1'b0, e.acc & e.am});
            chk({1'b0, cfg_o}, {1'b0, e.cfg});
            chk({8'h00, carry_o}, {8'h00, e.cy});
        end
    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        m_cfg = 8'hFF;
        // File registers get known random contents before the first edge
        for (int a = 0; a < 32; a++)
        begin
            fm[a] = 8'($random(seed));
            u_clr_exec.u_mem.mem[a] = fm[a];
        end
        repeat (10) @(posedge clock_i);
        #1;
        srst_i = 1'b0;
        chk({acc_o, carry_o}, 9'h000);
        chk({cfg_o, pc_load_o}, 9'h1FE);
        // Returns with boundary and random literals, each chased by a config load
        for (int i = 0; i < 6; i++)
        begin
            k = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
            stack_top_entry_i = 9'($random(seed));
            d = '{k, 8'hFF, m_cfg, stack_top_entry_i, 1'b1, 1'b0};
            issue({clr_pkg::OP_RET_HI, k}, clr_pkg::RET_CYCLES - 1, d);
            m_cfg = k;
            issue(12'h002, 0, '{k, 8'hFF, k, 9'h000, 1'b0, 1'b0});
        end
        $display("test return and config load done");
        foreach (bad[i])
            issue(bad[i], 0, '{k, 8'hFF, m_cfg, 9'h000, 1'b0, 1'b0});
        // Rotates: the first writes back, the second reads that register into
        // the accumulator, the rest pick address and destination at random
        m_acc = k;
        m_cy  = 1'b0;
        for (int i = 0; i < 10; i++)
        begin
            fa    = (i == 1) ? fa : 5'($random(seed));
            d_bit = (i < 2) ? ~i[0] : 1'($random(seed));
            r     = {fm[fa][6:0], m_cy};
            m_cy  = fm[fa][7];
            if (d_bit)
                fm[fa] = r;
            else
                m_acc = r;
            d = '{m_acc, 8'hFF, m_cfg, 9'h000, 1'b0, m_cy};
            issue({clr_pkg::OP_ROT_HI, d_bit, fa}, 1, d);
        end
        instr_valid_i = 1'b0;
        $display("test unknown opcodes and rotates done");
        // Fresh reset gives a known carry of zero to shift into bit 0
        srst_i = 1'b1;
        repeat (2) @(posedge clock_i);
        #1;
        srst_i = 1'b0;
        chk({acc_o, carry_o}, 9'h000);
        chk({cfg_o, pc_load_o}, 9'h1FE);
        fa = 5'($random(seed));
        r  = {fm[fa][6:0], 1'b0};
        d  = '{r, 8'hFF, 8'hFF, 9'h000, 1'b0, fm[fa][7]};
        issue({clr_pkg::OP_ROT_HI, 1'b0, fa}, 1, d);
        instr_valid_i = 1'b0;
        repeat (3) @(posedge clock_i);
        $display("test accumulator rotate done");
        conclude();
    end
endmodule // tb_clr_exec
`default_nettype wire
